// [hdl/dsl_common.sv]
// ****************************************************************
// shared constants
// ****************************************************************
package dsl_pkg;
  localparam int          WORD_W      = 16;
  localparam int          CNT_W       = 5;
  localparam int          SYNC_STAGES = 2;
  localparam logic [15:0] ZERO_CODE   = 16'h0000;
  localparam logic [15:0] MID_CODE    = 16'h8000;
  localparam logic [4:0]  FULL_COUNT  = 5'h10;
  localparam logic [4:0]  CNT_ZERO    = 5'h00;
  localparam logic [4:0]  CNT_ONE     = 5'h01;
  localparam logic [15:0] ALL_ONES    = 16'hffff;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// level synchroniser, one per pin
// ****************************************************************
module dsl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end
endmodule

`default_nettype wire

// [hdl/dsl_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - select low: shift serial data on clock edges
// - select high: serial clock ignored, register holds
// - select rising: copy 16-bit word into latch
// - data sampled on each rising serial clock while select low
// - unipolar clear forces latch to zero asynchronously
// - bipolar clear forces latch to midscale asynchronously
// - msb first; earliest bit ends on top
// - extra edges keep last sixteen bits only
// - low don't-care bits ignored for narrow versions
// - reset loads same value as clear
module dsl_top #(
  parameter bit BIPOLAR  = 1'b0,
  parameter int RES_BITS = 16
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        load_sel_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        async_clear_n,
  output logic [15:0]      dac_code,
  output logic             dac_update,
  output logic             word_short
);
  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [15:0] CLEAR_CODE = BIPOLAR ? dsl_pkg::MID_CODE : dsl_pkg::ZERO_CODE;
  localparam logic [15:0] CODE_MASK  = dsl_pkg::ALL_ONES << (dsl_pkg::WORD_W - RES_BITS);

  function automatic logic [15:0] keep_code(input logic [15:0] word);
    keep_code = word & CODE_MASK;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic sel_n_s;
  logic sclk_s;
  logic sdi_s;

  dsl_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (load_sel_n),
    .level (sel_n_s)
  );

  // clear release is seen synchronised, so a load never meets a half-released clear
  logic clr_n_s;

  dsl_sync #(.RESET_VAL(1'b1)) u_sync_clr (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (async_clear_n),
    .level (clr_n_s)
  );

  dsl_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (sclk),
    .level (sclk_s)
  );

  // same depth as the clock path keeps setup intact
  dsl_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
    .mclk  (mclk),
    .rstn  (rstn),
    .pin   (sdi),
    .level (sdi_s)
  );

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic sclk_prev_q;
  logic sel_prev_q;
  logic sclk_rise;
  logic sel_rise;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q  <= sel_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sel_rise  = sel_n_s && !sel_prev_q;

  // ****************************************************************
  // input shift register
  // ****************************************************************
  logic [15:0] shift_q;
  logic        shift_en;

  assign shift_en = !sel_n_s && sclk_rise;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_q <= dsl_pkg::ZERO_CODE;
    end else if (shift_en) begin
      shift_q <= {shift_q[14:0], sdi_s};
    end
  end

  // ****************************************************************
  // edge counter for short-frame status
  // ****************************************************************
  logic [4:0] edge_cnt_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      edge_cnt_q <= dsl_pkg::CNT_ZERO;
    end else if (sel_rise) begin
      edge_cnt_q <= dsl_pkg::CNT_ZERO;
    end else if (shift_en && edge_cnt_q != dsl_pkg::FULL_COUNT) begin
      edge_cnt_q <= edge_cnt_q + dsl_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      word_short <= 1'b0;
    end else if (sel_rise) begin
      word_short <= (edge_cnt_q != dsl_pkg::FULL_COUNT);
    end
  end

  // ****************************************************************
  // dac latch
  // ****************************************************************
  // clear pin acts as an async preset of the latch only; its release
  // is not synchronised, but the latch just holds a constant then
  always_ff @(posedge mclk or negedge async_clear_n) begin
    if (!async_clear_n) begin
      dac_code <= CLEAR_CODE;
    end else if (!rstn) begin
      dac_code <= CLEAR_CODE;
    end else if (sel_rise && clr_n_s) begin
      dac_code <= keep_code(shift_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dac_update <= 1'b0;
    end else begin
      dac_update <= sel_rise && clr_n_s;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_shift_on_edge;
    @(posedge mclk) disable iff (!rstn)
    shift_en |=> shift_q[15:1] == $past(shift_q[14:0]);
  endproperty
  a_shift_on_edge: assert property (p_shift_on_edge) else $error("shift register did not shift");

  property p_hold_when_high;
    @(posedge mclk) disable iff (!rstn)
    sel_n_s && $past(sel_n_s) |=> $stable(shift_q);
  endproperty
  a_hold_when_high: assert property (p_hold_when_high) else $error("shift register moved while deselected");

  property p_latch_on_rise;
    @(posedge mclk) disable iff (!rstn || !async_clear_n)
    sel_rise && clr_n_s |=> dac_code == keep_code($past(shift_q)) && dac_update;
  endproperty
  a_latch_on_rise: assert property (p_latch_on_rise) else $error("latch not loaded on select rise");

  property p_sample_bit;
    @(posedge mclk) disable iff (!rstn)
    shift_en |=> shift_q[0] == $past(sdi_s);
  endproperty
  a_sample_bit: assert property (p_sample_bit) else $error("wrong data bit sampled");

  property p_clear_zero;
    @(posedge mclk) disable iff (!rstn)
    !BIPOLAR && !async_clear_n |-> dac_code == dsl_pkg::ZERO_CODE;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not give zero");

  property p_clear_mid;
    @(posedge mclk) disable iff (!rstn)
    BIPOLAR && !async_clear_n |-> dac_code == dsl_pkg::MID_CODE;
  endproperty
  a_clear_mid: assert property (p_clear_mid) else $error("clear did not give midscale");

  property p_msb_moves_up;
    @(posedge mclk) disable iff (!rstn)
    shift_en |=> shift_q[15] == $past(shift_q[14]);
  endproperty
  a_msb_moves_up: assert property (p_msb_moves_up) else $error("bit order broken");

  property p_count_saturates;
    @(posedge mclk) disable iff (!rstn)
    edge_cnt_q == dsl_pkg::FULL_COUNT && !sel_rise |=> edge_cnt_q == dsl_pkg::FULL_COUNT;
  endproperty
  a_count_saturates: assert property (p_count_saturates) else $error("edge count left full");

  property p_short_flag;
    @(posedge mclk) disable iff (!rstn)
    sel_rise |=> word_short == ($past(edge_cnt_q) != dsl_pkg::FULL_COUNT);
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short frame flag wrong");

  property p_low_bits_dropped;
    @(posedge mclk) disable iff (!rstn)
    (dac_code & ~CODE_MASK) == dsl_pkg::ZERO_CODE;
  endproperty
  a_low_bits_dropped: assert property (p_low_bits_dropped) else $error("don't-care bits reached latch");

  property p_reset_value;
    @(posedge mclk)
    $past(!rstn) && rstn && async_clear_n |-> dac_code == CLEAR_CODE;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

  property p_mid_shape;
    @(posedge mclk) disable iff (!rstn)
    BIPOLAR && !async_clear_n |-> dac_code[15] && dac_code[14:0] == 15'h0000;
  endproperty
  a_mid_shape: assert property (p_mid_shape) else $error("midscale shape wrong");

  c_full_word:  cover property (@(posedge mclk) sel_rise && edge_cnt_q == dsl_pkg::FULL_COUNT);
  c_short_word: cover property (@(posedge mclk) sel_rise && edge_cnt_q != dsl_pkg::FULL_COUNT);
  c_clear:      cover property (@(posedge mclk) rstn && !async_clear_n);
  c_long_word:  cover property (@(posedge mclk) shift_en && edge_cnt_q == dsl_pkg::FULL_COUNT);
endmodule

`default_nettype wire

// [sim/dsl_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host side of the three-wire link
// ****************************************************************
module dsl_host (
  input  wire logic mclk,
  output var logic  load_sel_n,
  output var logic  sclk,
  output var logic  sdi
);
  initial begin
    load_sel_n = 1'b1;
    sclk       = 1'b0;
    sdi        = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge mclk);
  endtask
  // n low bits of w; sclk stands low between frames
  task automatic send(input logic [23:0] w, input int n);
    load_sel_n <= 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sdi  <= w[i];
      sclk <= 1'b0;
      half();
      sclk <= 1'b1;
      half();
    end
    sclk <= 1'b0;
    half();
    load_sel_n <= 1'b1;
    // released line must not keep showing the last bit
    sdi        <= ~sdi;
    half();
  endtask
  task automatic idle_clocks(input int n);
    repeat (n) begin
      sclk <= ~sclk;
      sdi  <= ~sdi;
      half();
    end
  endtask
endmodule
`default_nettype wire

// [sim/dsl_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
// ****************************************************************
// two variants share one link: unipolar 16-bit and bipolar 12-bit
// ****************************************************************
module dsl_top_tb;
  logic        mclk;
  logic        rstn;
  logic        async_clear_n;
  logic        load_sel_n;
  logic        sclk;
  logic        sdi;
  logic [15:0] code_u;
  logic [15:0] code_b;
  logic        upd_u;
  logic        upd_b;
  logic        short_u;
  logic        short_b;
  int          error_cnt;
  int          check_count;

  dsl_host host (.mclk(mclk), .load_sel_n(load_sel_n), .sclk(sclk), .sdi(sdi));
  dsl_top #(.BIPOLAR(1'b0), .RES_BITS(16)) dut (.mclk(mclk), .rstn(rstn), .load_sel_n(load_sel_n),
    .sclk(sclk), .sdi(sdi), .async_clear_n(async_clear_n), .dac_code(code_u), .dac_update(upd_u),
    .word_short(short_u));
  dsl_top #(.BIPOLAR(1'b1), .RES_BITS(12)) dut_bip (.mclk(mclk), .rstn(rstn), .load_sel_n(load_sel_n),
    .sclk(sclk), .sdi(sdi), .async_clear_n(async_clear_n), .dac_code(code_b), .dac_update(upd_b),
    .word_short(short_b));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // expects the pulse within a bounded span, or none when upd is 0
  task automatic load(input logic [23:0] w, input int n, input logic upd,
                      input logic [15:0] eu, input logic [15:0] eb);
    logic seen;
    seen = 1'b0;
    fork
      host.send(w, n);
      repeat (n * 8 + 30) @(negedge mclk) if (upd_u === 1'b1 && upd_b === 1'b1) seen = 1'b1;
    join
    @(posedge mclk);
    `CHK("update", upd, seen)
    `CHK("code_u", eu, code_u)
    `CHK("code_b", eb, code_b)
  endtask

  task automatic t_reset();
    `CHK("rst_u", 16'h0000, code_u)
    `CHK("rst_b", 16'h8000, code_b)
  endtask

  task automatic t_words();
    load(24'h00_a5c3, 16, 1'b1, 16'ha5c3, 16'ha5c0);
    `CHK("short", 1'b0, short_u)
    load(24'h0f_1234, 20, 1'b1, 16'h1234, 16'h1230);
    load(24'h00_00ff, 8, 1'b1, 16'h34ff, 16'h34f0);
    `CHK("short8", 1'b1, short_u)
    `CHK("short8b", 1'b1, short_b)
  endtask

  task automatic t_idle();
    load(24'h00_8001, 16, 1'b1, 16'h8001, 16'h8000);
    host.idle_clocks(7);
    `CHK("idle", 16'h8001, code_u)
  endtask

  task automatic t_clear();
    @(posedge mclk);
    async_clear_n <= 1'b0;
    #2;
    `CHK("clr_u", 16'h0000, code_u)
    `CHK("clr_b", 16'h8000, code_b)
    load(24'h00_ffff, 16, 1'b0, 16'h0000, 16'h8000);
    async_clear_n <= 1'b1;
    load(24'h00_7ffe, 16, 1'b1, 16'h7ffe, 16'h7ff0);
  endtask

  initial begin
    error_cnt     = 0;
    check_count   = 0;
    rstn          = 1'b0;
    async_clear_n = 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_words();
    t_idle();
    t_clear();
    conclude();
  end

  // run needs about 960 mclk cycles
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
